// file: bench/jla_props.sv
// Pin-level checks on the outbound link and the overrun flag of the cache access port
`timescale 1ns/10ps
`default_nettype none
module jla_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic out_data_o,
	input wire logic out_vld_o,
	input wire logic busy_o,
	input wire logic rd_overrun_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [6:0] gap_q;
	// Cycles since the last strobe; a launch may raise busy one cycle before its strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) gap_q <= 7'h0;
		else if (out_vld_o) gap_q <= 7'h1;
		else if (busy_o) gap_q <= gap_q + 7'h1;
		else gap_q <= 7'h0;
	end
	property p_vld_pulse; out_vld_o |=> !out_vld_o; endproperty
	a_vld_pulse: assert property (p_vld_pulse) else $error("strobe too long");
	property p_vld_gap; out_vld_o |-> (gap_q < 7'h2 || gap_q == 7'h40); endproperty
	a_vld_gap: assert property (p_vld_gap) else $error("strobe spacing wrong");
	property p_vld_busy; out_vld_o |-> busy_o; endproperty
	a_vld_busy: assert property (p_vld_busy) else $error("strobe while idle");
	property p_word_run; out_vld_o |-> ##63 busy_o; endproperty
	a_word_run: assert property (p_word_run) else $error("word cut short");
	property p_idle_quiet; !busy_o |-> !out_vld_o && !out_data_o; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("link not quiet");
	property p_busy_start; $rose(busy_o) |-> ##[0:1] out_vld_o; endproperty
	a_busy_start: assert property (p_busy_start) else $error("no strobe at start");
	property p_busy_end; $fell(busy_o) |-> gap_q == 7'h40; endproperty
	a_busy_end: assert property (p_busy_end) else $error("word length wrong");
	property p_ovr_hold; rd_overrun_o |=> rd_overrun_o; endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("overrun flag lost");
endmodule : jla_props
bind jla_top jla_props u_props (.clk_i, .rst_n_i, .out_data_o, .out_vld_o, .busy_o, .rd_overrun_o);
`default_nettype wire

// file: bench/jla_siu_model.sv
// Behavioural model of the system interface unit at the far end of the link
`timescale 1ns/10ps
`default_nettype none
module jla_siu_model (
	input  wire logic clk_i,
	input  wire logic out_data_i,
	input  wire logic out_vld_i,
	output logic      in_data_o,
	output logic      in_vld_o
);
	logic [63:0] mem [logic [39:0]];
	logic [63:0] got_addr;
	logic [63:0] got_data;
	int          lat = 0;
	// Take one word, strobe cycle first, one bit a cycle, read mid-cycle where it is settled
	task automatic take(output logic [63:0] w);
		for (int i = 0; i < 64; i++) begin
			w[i] = out_data_i;
			@(negedge clk_i);
		end
	endtask : take
	// Send a word bit 0 first; released line shows the inverse of its last bit
	task automatic ret(input logic [63:0] w);
		for (int i = 0; i < 64; i++) begin
			@(negedge clk_i);
			in_vld_o = (i == 0);
			in_data_o = w[i];
		end
		@(negedge clk_i);
		in_vld_o = 1'b0;
		in_data_o = ~w[63];
	endtask : ret
	// Address first; data follows only for a write; bit 2 forced low on the key
	initial begin
		logic [39:0] key;
		in_vld_o = 1'b0;
		in_data_o = 1'b0;
		forever begin
			@(negedge clk_i iff out_vld_i);
			take(got_addr);
			key = {got_addr[39:3], 1'b0, got_addr[1:0]};
			if (got_addr[62:56] == jla_pkg::CMD_WRITE) begin
				take(got_data);
				mem[key] = got_data;
			end else begin
				repeat (lat) @(posedge clk_i);
				ret(mem[key]);
			end
		end
	end
endmodule : jla_siu_model
`default_nettype wire

// file: bench/test_jla_top.sv
// Self-checking bench for the cache access port
`timescale 1ns/10ps
`default_nettype none
module test_jla_top;
	logic                clk = 1'b0, tck = 1'b0, tck_en = 1'b0, rst_n = 1'b0;
	logic                tdi = 1'b0, cap = 1'b0, sh = 1'b0, upd = 1'b0, ri = 1'b0;
	logic                tdo, odat, ovld, idat, ivld, busy, ovr;
	jla_pkg::jla_instr_t ins = jla_pkg::INSTR_OTHER;
	logic [15:0]         seed = 16'h28fe;
	logic [64:0]         o, w;
	logic [63:0]         d;
	logic [39:0]         a;
	int                  err_total = 0;
	int                  n_compared = 0;
	always #2 clk = ~clk;
	// TAP clock parks low while halted; offset keeps its edges off the core edges
	initial begin
		#1.3;
		forever #24 tck = tck_en ? ~tck : 1'b0;
	end
	jla_top DUT (.clk_i(clk), .rst_n_i(rst_n), .tck_i(tck), .tdi_i(tdi), .instr_i(ins),
		.capture_dr_i(cap), .shift_dr_i(sh), .update_dr_i(upd), .run_idle_i(ri), .tdo_o(tdo),
		.out_data_o(odat), .out_vld_o(ovld), .in_data_i(idat), .in_vld_i(ivld), .busy_o(busy),
		.rd_overrun_o(ovr));
	jla_siu_model u_siu (.clk_i(clk), .out_data_i(odat), .out_vld_i(ovld), .in_data_o(idat),
		.in_vld_o(ivld));
	function automatic logic [64:0] acmd(input logic [6:0] c, input logic [39:0] x);
		return {1'b1, c, 16'h0, x, 1'b0};
	endfunction : acmd
	// 64 bits from four one-step advances of the 16-bit shift register, each state packed in turn
	function automatic logic [63:0] rnd();
		logic [63:0] r;
		r = 64'h0;
		repeat (4) begin
			seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
			r = {r[47:0], seed};
		end
		return r;
	endfunction : rnd
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Capture, 65 shifts and update; bit 0 leaves first
	task automatic dr(input jla_pkg::jla_instr_t i, input logic [64:0] v);
		@(negedge tck);
		ins = i;
		cap = 1'b1;
		@(negedge tck);
		cap = 1'b0;
		sh = 1'b1;
		for (int k = 0; k < 65; k++) begin
			tdi = v[k];
			o[k] = tdo;
			@(negedge tck);
		end
		sh = 1'b0;
		upd = 1'b1;
		@(negedge tck);
		upd = 1'b0;
	endtask : dr
	// One visit to run-test-idle under a go instruction
	task automatic go(input jla_pkg::jla_instr_t i, input int n);
		@(negedge tck);
		ins = i;
		ri = 1'b1;
		repeat (n) @(negedge tck);
		ri = 1'b0;
	endtask : go
	task automatic complete_run;
		$display("compares %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		tck_en = 1'b1;
		dr(jla_pkg::INSTR_LOAD_CACHE_ADDRESS, 65'h0);
		chk(o[64:1], jla_pkg::ADDR_RST[64:1]);
		$display("reset test done");
		// Prompt, slow and very slow returns; reads use bit 2 set on purpose
		for (int k = 0; k < 3; k++) begin
			d = rnd();
			a = {d[39:3], 3'h0};
			d = rnd();
			u_siu.lat = k * 1000;
			w = acmd(jla_pkg::CMD_WRITE, a);
			dr(jla_pkg::INSTR_LOAD_CACHE_ADDRESS, w);
			dr(jla_pkg::INSTR_LOAD_CACHE_WRITE_DATA, {d, 1'b0});
			go(jla_pkg::INSTR_CACHE_WRITE_GO, jla_pkg::RTI_WR_TCK);
			chk(u_siu.got_addr, w[64:1]);
			chk(u_siu.got_data, d);
			w = acmd(jla_pkg::CMD_READ, a | 40'h4);
			dr(jla_pkg::INSTR_LOAD_CACHE_ADDRESS, w);
			go(jla_pkg::INSTR_CACHE_READ_GO, jla_pkg::RTI_RD_TCK);
			chk(u_siu.got_addr, w[64:1]);
			dr(jla_pkg::INSTR_CACHE_READ_GO, 65'h0);
			if (k == 2) chk({63'h0, o[0]}, 64'h0);
			for (int t = 0; t < 30 && o[0] !== 1'b1; t++) dr(jla_pkg::INSTR_CACHE_READ_GO, 65'h0);
			chk({63'h0, o[0]}, 64'h1);
			chk(o[64:1], d);
			dr(jla_pkg::INSTR_LOAD_CACHE_WRITE_DATA, o);
			chk(o[64:1], d);
			$display("access pair %0d done", k);
		end
		chk({63'h0, ovr}, 64'h0);
		// Halted TAP clock stalls the drain, so returns pile up in the buffer
		tck_en = 1'b0;
		d = rnd();
		repeat (4) u_siu.ret(d);
		repeat (2) @(negedge clk);
		chk({63'h0, ovr}, 64'h1);
		$display("overrun test done");
		// Reset in mid-run is the only way to clear the sticky overrun flag
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk({63'h0, ovr}, 64'h0);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk({63'h0, ovr}, 64'h0);
		$display("mid-run reset test done");
		complete_run;
	end
	// Tests take about 25,000 core cycles; twice that means a hang
	initial begin
		#200000;
		err_total++;
		complete_run;
	end
endmodule : test_jla_top
`default_nettype wire

// file: src/jla_pkg.sv
// Constants and types shared by the cache access port
package jla_pkg;
	localparam int          REG_W      = 65;       // Width of each access register
	localparam int          WORD_W     = 64;       // Payload width, bits 64..1
	localparam int          CNT_W      = 6;        // Bit counter for one payload word
	localparam int          ACCESS_BIT = 64;       // Marks a debug-port access
	localparam int          CMD_HI     = 63;       // Command field top bit
	localparam int          CMD_LO     = 57;       // Command field bottom bit
	localparam int          UNUSED_HI  = 56;       // Unused field top bit
	localparam int          UNUSED_LO  = 41;       // Unused field bottom bit
	localparam int          ADDR_HI    = 40;       // Physical address top bit
	localparam int          ADDR_LO    = 1;        // Physical address bottom bit
	localparam int          VALID_BIT  = 0;        // Read-data valid flag
	localparam logic [6:0]  CMD_READ   = 7'h01;    // Command code for a read
	localparam logic [6:0]  CMD_WRITE  = 7'h02;    // Command code for a write
	localparam logic [64:0] ADDR_RST   = 65'h0;    // Reset value, address/command
	localparam logic [64:0] DATA_RST   = 65'h0;    // Reset value, shared data register
	localparam int          RTI_WR_TCK = 128;      // Least idle TCK cycles for a write
	localparam int          RTI_RD_TCK = 64;       // Least idle TCK cycles for a read
	localparam int          BUF_DEPTH  = 2;        // Returned-word buffer entries

	// Instruction decode handed in by the TAP
	typedef enum logic [2:0] {
		INSTR_OTHER                 = 3'b000,
		INSTR_LOAD_CACHE_ADDRESS    = 3'b001,
		INSTR_LOAD_CACHE_WRITE_DATA = 3'b010,
		INSTR_CACHE_WRITE_GO        = 3'b011,
		INSTR_CACHE_READ_GO         = 3'b100
	} jla_instr_t;

	// Outbound serializer states
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_ADDR = 2'b01,
		SER_DATA = 2'b10
	} jla_ser_t;
endpackage : jla_pkg

// file: src/jla_top.sv
// Debug-port access path from the TAP data registers to the cache interface
//
// What this block does
// - Address/command top bit marks access; bits 63..57 hold read or write code.
// - Address bits 40..1 are the 8-byte aligned address; 56..41 unused, 0 ignored.
// - Write data and read data share one physical 65-bit register.
// - Bit 0 of read data is the valid flag, shifted out first.
// - Write: load address, load data, select write-go, then 128+ TCK in idle.
// - Read: load address, select read-go, then 64+ TCK in idle.
// - Send address bits 64..1 LSB first, then write data likewise for writes.
// - Pulse outbound valid with bit 1 of address and bit 1 of data.
// - Path works while the chip runs, with no clock stopped.
`timescale 1ns/10ps
`default_nettype none

module jla_top #(
	parameter int DEPTH = jla_pkg::BUF_DEPTH
) (
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               tck_i,
	input  wire logic               tdi_i,
	input  wire jla_pkg::jla_instr_t instr_i,
	input  wire logic               capture_dr_i,
	input  wire logic               shift_dr_i,
	input  wire logic               update_dr_i,
	input  wire logic               run_idle_i,
	output logic                    tdo_o,
	output logic                    out_data_o,
	output logic                    out_vld_o,
	input  wire logic               in_data_i,
	input  wire logic               in_vld_i,
	output logic                    busy_o,
	output logic                    rd_overrun_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [jla_pkg::CNT_W-1:0] LAST_BIT = {jla_pkg::CNT_W{1'b1}};

	// ---------------- TCK domain ----------------
	logic [jla_pkg::REG_W-1:0]  sr_q;       // Shared capture/shift stage
	logic [jla_pkg::REG_W-1:0]  addr_q;     // Address/command register
	logic [jla_pkg::REG_W-1:0]  data_q;     // Write data and read data in one
	logic                       fired_q;    // Transfer already launched this instruction
	logic                       req_tgl_q;  // Launch event toward clk domain
	logic                       is_wr_q;    // Launched transfer is a write
	logic                       rsp_s1_q;
	logic                       rsp_s2_q;
	logic                       rsp_s3_q;
	logic                       go_instr;
	logic                       launch_t;
	logic                       rsp_edge_t;

	// ---------------- clk domain ----------------
	logic                       req_s1_q;
	logic                       req_s2_q;
	logic                       req_s3_q;
	jla_pkg::jla_ser_t          ser_q;
	logic [jla_pkg::CNT_W-1:0]  ocnt_q;
	logic [jla_pkg::WORD_W-1:0] osh_q;
	logic                       owr_q;
	logic                       odata_q;
	logic                       ovld_q;
	logic                       busy_q;     // Link carries a word, launch to last bit
	logic [jla_pkg::WORD_W-1:0] rcv_q;
	logic [jla_pkg::CNT_W-1:0]  rcnt_q;
	logic                       ract_q;
	logic                       ovr_q;
	logic [jla_pkg::WORD_W-1:0] mem_q [DEPTH];
	logic [PW-1:0]              wptr_q;
	logic [PW-1:0]              rptr_q;
	logic [CW-1:0]              cnt_q;
	logic [jla_pkg::WORD_W-1:0] xfer_q;     // Word held stable for the TCK side
	logic                       rsp_tgl_q;
	logic                       ack_s1_q;
	logic                       ack_s2_q;
	logic                       launch_c;
	logic                       push;
	logic                       push_ready;
	logic                       pop;
	logic                       buf_empty;
	logic [jla_pkg::WORD_W-1:0] push_word;

	// Go fires once on the first idle cycle of a go instruction; re-entry does nothing
	assign go_instr   = (instr_i == jla_pkg::INSTR_CACHE_WRITE_GO) ||
	                    (instr_i == jla_pkg::INSTR_CACHE_READ_GO);
	assign launch_t   = go_instr && run_idle_i && !fired_q;
	assign rsp_edge_t = rsp_s2_q ^ rsp_s3_q;

	// Serial data register stage: capture, shift LSB-first toward TDO
	always_ff @(posedge tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sr_q <= jla_pkg::DATA_RST;
		end else if (capture_dr_i) begin
			case (instr_i)
				jla_pkg::INSTR_LOAD_CACHE_ADDRESS: sr_q <= addr_q;
				jla_pkg::INSTR_LOAD_CACHE_WRITE_DATA,
				jla_pkg::INSTR_CACHE_READ_GO:      sr_q <= data_q;
				default:                           sr_q <= sr_q;
			endcase
		end else if (shift_dr_i) begin
			sr_q <= {tdi_i, sr_q[jla_pkg::REG_W-1:1]};          // Bit 0 leaves first
		end
	end

	assign tdo_o = sr_q[0];

	// Address/command register; fields are passed on untouched
	always_ff @(posedge tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_q <= jla_pkg::ADDR_RST;
		end else if (update_dr_i && instr_i == jla_pkg::INSTR_LOAD_CACHE_ADDRESS) begin
			addr_q <= sr_q;
		end
	end

	// Shared data register: write payload, then returned read word with valid flag
	always_ff @(posedge tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_q <= jla_pkg::DATA_RST;
		end else if (rsp_edge_t) begin
			data_q <= {xfer_q, 1'b1};
		end else if (launch_t && instr_i == jla_pkg::INSTR_CACHE_READ_GO) begin
			data_q[jla_pkg::VALID_BIT] <= 1'b0;                 // Stale flag cleared
		end else if (update_dr_i && instr_i == jla_pkg::INSTR_LOAD_CACHE_WRITE_DATA) begin
			data_q <= sr_q;
		end
	end

	// Launch bookkeeping; nothing here holds addr_q and data_q still while the clk side reads them
	// The core side reads addr_q, data_q and is_wr_q with no synchroniser of its own:
	// the launch toggle reaches it only after they have settled, and a host that
	// reloads them mid-transfer gets a mixed word, which is its own fault.
	always_ff @(posedge tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fired_q   <= 1'b0;
			req_tgl_q <= 1'b0;
			is_wr_q   <= 1'b0;
		end else begin
			fired_q <= go_instr && (fired_q || run_idle_i);
			if (launch_t) begin
				req_tgl_q <= ~req_tgl_q;
				is_wr_q   <= (instr_i == jla_pkg::INSTR_CACHE_WRITE_GO);
			end
		end
	end

	// Response toggle synchroniser; third stage doubles as the acknowledge
	always_ff @(posedge tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_s1_q <= 1'b0;
			rsp_s2_q <= 1'b0;
			rsp_s3_q <= 1'b0;
		end else begin
			rsp_s1_q <= rsp_tgl_q;
			rsp_s2_q <= rsp_s1_q;
			rsp_s3_q <= rsp_s2_q;
		end
	end

	// Launch toggle synchroniser into the core clock
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	assign launch_c = req_s2_q ^ req_s3_q;

	// Outbound serializer: address word, then data word for writes, LSB first
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ser_q   <= jla_pkg::SER_IDLE;
			ocnt_q  <= '0;
			osh_q   <= '0;
			owr_q   <= 1'b0;
			odata_q <= 1'b0;
			ovld_q  <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			case (ser_q)
				jla_pkg::SER_IDLE: begin
					odata_q <= 1'b0;
					ovld_q  <= 1'b0;
					busy_q  <= launch_c;                       // Busy leads the strobe by one
					if (launch_c) begin                        // Runs on the live clock
						osh_q  <= addr_q[jla_pkg::REG_W-1:1];
						owr_q  <= is_wr_q;
						ocnt_q <= '0;
						ser_q  <= jla_pkg::SER_ADDR;
					end
				end
				jla_pkg::SER_ADDR, jla_pkg::SER_DATA: begin
					odata_q <= osh_q[0];
					busy_q  <= 1'b1;
					ovld_q  <= (ocnt_q == '0);
					osh_q   <= osh_q >> 1;
					ocnt_q  <= ocnt_q + 1'b1;
					if (ocnt_q == LAST_BIT) begin
						if (ser_q == jla_pkg::SER_ADDR && owr_q) begin
							osh_q <= data_q[jla_pkg::REG_W-1:1];  // Data follows back to back
							ser_q <= jla_pkg::SER_DATA;
						end else begin
							ser_q <= jla_pkg::SER_IDLE;        // Reads carry no data
						end
					end
				end
				default: ser_q <= jla_pkg::SER_IDLE;
			endcase
		end
	end

	assign out_data_o = odata_q;
	assign out_vld_o  = ovld_q;
	// Busy drops only after the last bit has left, so a low busy means a quiet link
	assign busy_o     = busy_q;

	// Inbound deserializer: valid marks bit 0, 63 more follow on consecutive cycles
	assign push      = ract_q && (rcnt_q == LAST_BIT);
	assign push_word = {in_data_i, rcv_q[jla_pkg::WORD_W-1:1]};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rcv_q  <= '0;
			rcnt_q <= '0;
			ract_q <= 1'b0;
		end else if (in_vld_i) begin
			rcv_q  <= {in_data_i, rcv_q[jla_pkg::WORD_W-1:1]};  // Bit 0 first
			rcnt_q <= {{(jla_pkg::CNT_W-1){1'b0}}, 1'b1};
			ract_q <= 1'b1;
		end else if (ract_q) begin
			rcv_q  <= push_word;
			rcnt_q <= rcnt_q + 1'b1;
			ract_q <= !push;
		end
	end

	// Returned-word buffer; a slow TCK side stalls the pop, not the arriving word
	assign buf_empty  = (cnt_q == '0);
	assign push_ready = (cnt_q != CW'(DEPTH));
	assign pop        = !buf_empty && (ack_s2_q == rsp_tgl_q);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			if (push && push_ready) begin
				mem_q[wptr_q] <= push_word;
				wptr_q        <= (wptr_q == PW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= (rptr_q == PW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
			end
			cnt_q <= cnt_q + CW'(push && push_ready) - CW'(pop);
		end
	end

	// Sticky overrun: set by a returned word that arrives while the buffer is full
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovr_q <= 1'b0;
		end else if (push && !push_ready) begin
			ovr_q <= 1'b1;
		end
	end

	assign rd_overrun_o = ovr_q;

	// Word handshake toward TCK: hold xfer_q until the acknowledge returns
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xfer_q    <= '0;
			rsp_tgl_q <= 1'b0;
			ack_s1_q  <= 1'b0;
			ack_s2_q  <= 1'b0;
		end else begin
			ack_s1_q <= rsp_s3_q;
			ack_s2_q <= ack_s1_q;
			if (pop) begin
				xfer_q    <= mem_q[rptr_q];
				rsp_tgl_q <= ~rsp_tgl_q;
			end
		end
	end
endmodule : jla_top

`default_nettype wire
